//--- sim/see_core_props.sv
// assertions for the serial eeprom command engine
`timescale 1ns/10ps
`default_nettype none
module see_core_props #(
  parameter PROG_CYC = 20,
  parameter FILL_CYC = 20
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic select,
  input wire logic link_clk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en_n,
  input wire logic busy
);
  logic        lk_reg;
  logic [3:0]  since_reg;
  logic [31:0] run_reg;
  // cycles since last raw link rise, length of busy run
  always @(posedge core_clk) begin
    lk_reg <= link_clk;
    if (!reset_n || (link_clk && !lk_reg))
      since_reg <= 4'h0;
    else
      since_reg <= since_reg + {3'h0, since_reg != 4'hF};
    run_reg <= busy ? run_reg + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_rel; $fell(select) |-> ##[1:5] serial_out_en_n; endproperty
  a_rel: assert property (p_rel) else $error("output not released");
  property p_dummy; $fell(serial_out_en_n) && !busy |-> !serial_out; endproperty
  a_dummy: assert property (p_dummy) else $error("no leading zero");
  property p_busy0; busy && $past(busy) && !serial_out_en_n |-> !serial_out; endproperty
  a_busy0: assert property (p_busy0) else $error("status high while busy");
  property p_ready; $fell(busy) && !serial_out_en_n |-> ##[0:2] serial_out; endproperty
  a_ready: assert property (p_ready) else $error("status not ready");
  property p_edge;
    $changed(serial_out) && !serial_out_en_n && !$past(serial_out_en_n) && !busy
      && !$past(busy) && !$past(busy, 2) |-> since_reg <= 4'h5;
  endproperty
  a_edge: assert property (p_edge) else $error("output changed off rising edge");
  property p_start; $rose(busy) |-> since_reg <= 4'h7; endproperty
  a_start: assert property (p_start) else $error("cycle not started by last bit");
  property p_hold; $rose(busy) |-> busy[*8]; endproperty
  a_hold: assert property (p_hold) else $error("cycle cut short");
  // fill walks all 128 words twice around its timed wait
  property p_end; busy |-> run_reg <= FILL_CYC + 2 * 128 + 8; endproperty
  a_end: assert property (p_end) else $error("cycle never ends");
endmodule
bind see_core see_core_props #(.PROG_CYC(PROG_CYC), .FILL_CYC(FILL_CYC)) see_core_props_inst (
  .core_clk(core_clk), .reset_n(reset_n), .select(select), .link_clk(link_clk),
  .serial_in(serial_in), .serial_out(serial_out), .serial_out_en_n(serial_out_en_n), .busy(busy));
`default_nettype wire

//--- sim/see_host.sv
// host model driving select, link clock and serial data
`timescale 1ns/10ps
`default_nettype none
module see_host (
  input  wire logic        core_clk,
  input  wire logic        serial_out,
  input  wire logic        serial_out_en_n,
  output var  logic        select,
  output var  logic        link_clk,
  output var  logic        serial_in,
  output var  logic [39:0] rx
);
  // released line shows inverse of last value
  wire line_w = serial_out_en_n ? ~serial_out : serial_out;
  initial begin
    select = 1'b0;
    link_clk = 1'b0;
    serial_in = 1'b0;
    rx = 40'h0;
  end
  // n bits msb first, samples line before each bit
  task xfer(input logic [39:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      rx <= {rx[38:0], line_w};
      select <= 1'b1;
      serial_in <= v[i];
      link_clk <= 1'b0;
      repeat (4) @(posedge core_clk);
      link_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
  endtask
  // link clock stands low between frames
  task done;
    link_clk <= 1'b0;
    select <= 1'b0;
    repeat (12) @(posedge core_clk);
  endtask
  task poll(output logic first, output int n);
    select <= 1'b0;
    repeat (12) @(posedge core_clk);
    select <= 1'b1;
    repeat (6) @(posedge core_clk);
    first = line_w;
    n = 0;
    while (!line_w && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    select <= 1'b0;
    repeat (12) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the serial eeprom command engine
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk;
  logic reset_n;
  wire  select, link_clk, serial_in, serial_out, serial_out_en_n, busy;
  wire  [39:0] rx;
  int   errors;
  int   compares;
  see_core #(.PROG_CYC(60), .FILL_CYC(100)) see_core_inst (.core_clk(core_clk),
    .reset_n(reset_n), .select(select), .link_clk(link_clk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en_n(serial_out_en_n), .busy(busy));
  see_host see_host_inst (.core_clk(core_clk), .serial_out(serial_out),
    .serial_out_en_n(serial_out_en_n), .select(select), .link_clk(link_clk),
    .serial_in(serial_in), .rx(rx));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task cmd(input logic [1:0] op, input logic [7:0] f, input logic [15:0] d, input int n);
    see_host_inst.xfer({13'h0, 1'b1, op, f, d} >> (27 - n), n);
  endtask
  task rd(input logic [7:0] a, input int n);
    see_host_inst.xfer(40'h0, 2);
    cmd(2'h2, a, 16'h0, 11);
    see_host_inst.xfer(40'h0, n);
    see_host_inst.done;
  endtask
  task pw;
    logic first;
    int   n;
    see_host_inst.poll(first, n);
    chk(first, 1'b0);
    if (n >= 400) begin
      errors++;
      stop_test;
    end else begin
      chk(busy, 1'b0);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    cmd(2'h1, a, d, 27);
    see_host_inst.done;
  endtask
  task t_locked;
    cmd(2'h0, 8'h40, 16'h1111, 27);
    see_host_inst.done;
    chk(busy, 1'b0);
    $display("test locked done");
  endtask
  task t_fill;
    cmd(2'h0, 8'hC0, 16'h0, 11);
    see_host_inst.done;
    wr(8'h00, 16'h0F0F);
    pw;
    cmd(2'h0, 8'h40, 16'hA5C3, 27);
    see_host_inst.done;
    chk(busy, 1'b1);
    pw;
    rd(8'h00, 17);
    chk(rx[16:0], {1'b0, 16'hA5C3});
    $display("test fill done");
  endtask
  task t_wrap;
    wr(8'h00, 16'h3C96);
    chk(busy, 1'b1);
    pw;
    rd(8'h7F, 33);
    chk(rx[32:0], {1'b0, 16'hA5C3, 16'h3C96});
    $display("test wrap done");
  endtask
  task t_disabled;
    cmd(2'h0, 8'h00, 16'h0, 11);
    see_host_inst.done;
    wr(8'h01, 16'h1234);
    chk(busy, 1'b0);
    rd(8'h00, 33);
    chk(rx[32:0], {1'b0, 16'h3C96, 16'hA5C3});
    $display("test disabled done");
  endtask
  initial begin
    reset_n = 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_locked;
    t_fill;
    t_wrap;
    t_disabled;
    stop_test;
  end
endmodule
`default_nettype wire

//--- src/see_core.v
// serial eeprom read, write and fill command engine (x16 organization)
// How it works
// R1 - read sends zero bit then 16 data bits
// R2 - output bit changes on rising link clock
// R3 - held select keeps reading next locations
// R4 - host supplies 16 data bits after write
// R5 - last write bit starts timed erase-program
// R6 - select low 250ns then high shows status; code shows it only if prog_busy at the select rise
// R7 - status low while busy, high when done
// R8 - fill writes all, starts on last bit
// R9 - fill finishes with no further link clocks
// R10 - fill erases whole array before programming
// R11 - fill only runs when programming enabled
// R12 - fill cycle also shows polled status
// R13 - start is first edge with select, data high; code ignores it while prog_busy
// R14 - reset leaves programming disabled
// R15 - output released when select falls
// R16 - read works whether enabled or not
// R17 - sequential read wraps to location zero
`timescale 1ns/10ps
`default_nettype none
`include "see_regs.vh"
module see_core #(
  parameter PROG_CYC = `SEE_PROG_CYC,
  parameter FILL_CYC = `SEE_FILL_CYC
) (
  input  wire core_clk,
  input  wire reset_n,
  input  wire select,
  input  wire link_clk,
  input  wire serial_in,
  output reg  serial_out,
  output reg  serial_out_en_n,
  output reg  busy
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_HEAD = 5'h02;
  localparam [4:0] ST_DATA = 5'h04;
  localparam [4:0] ST_READ = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;
  localparam [1:0] PH_IDLE = 2'h0;
  localparam [1:0] PH_ERASE = 2'h1;
  localparam [1:0] PH_PROG = 2'h2;

  reg [`SEE_DATA_W-1:0] mem [0:`SEE_WORDS-1];
  reg [2:0] sel_sync_reg;
  reg [2:0] clk_sync_reg;
  reg [1:0] din_sync_reg;
  reg [4:0] state_reg;
  reg [4:0] cnt_reg;
  reg [9:0] head_reg;
  reg [`SEE_DATA_W-1:0] shift_reg;
  reg [`SEE_ADDR_W-1:0] addr_reg;
  reg                   enable_reg;
  reg [1:0]             phase_reg;
  reg                   fill_reg;
  reg [31:0]            timer_reg;
  reg [`SEE_ADDR_W-1:0] fill_idx_reg;
  reg [`SEE_DATA_W-1:0] wdata_reg;
  reg [`SEE_ADDR_W-1:0] waddr_reg;
  reg [15:0]            low_cnt_reg;
  reg                   poll_reg;

  wire sel_s    = sel_sync_reg[1];
  wire sel_fall = sel_sync_reg[2] & ~sel_sync_reg[1];
  wire sel_rise = ~sel_sync_reg[2] & sel_sync_reg[1];
  wire clk_rise = ~clk_sync_reg[2] & clk_sync_reg[1];
  wire din_s    = din_sync_reg[1];
  wire prog_busy = (phase_reg != PH_IDLE);
  wire [9:0] head_next = {head_reg[8:0], din_s};
  wire [`SEE_OP_W-1:0] op_code = head_next[9:8];
  wire [1:0] sub_code = head_next[7:6];

  always @(posedge core_clk) begin
    if (!reset_n) begin
      sel_sync_reg <= 3'h0;
      clk_sync_reg <= 3'h0;
      din_sync_reg <= 2'h0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], select};
      clk_sync_reg <= {clk_sync_reg[1:0], link_clk};
      din_sync_reg <= {din_sync_reg[0], serial_in};
    end
  end

  // erase and program engine
  always @(posedge core_clk) begin
    if (!reset_n) begin
      phase_reg    <= PH_IDLE;
      timer_reg    <= 32'h0;
      fill_idx_reg <= {`SEE_ADDR_W{1'b0}};
    end else if (phase_reg == PH_ERASE) begin
      if (fill_reg) begin
        mem[fill_idx_reg] <= `SEE_ERASED; // [R10]
        fill_idx_reg <= fill_idx_reg + 1'b1;
        if (fill_idx_reg == `SEE_WORDS - 1)
          phase_reg <= PH_PROG;
      end else begin
        mem[waddr_reg] <= `SEE_ERASED; // [R5]
        phase_reg <= PH_PROG;
      end
    end else if (phase_reg == PH_PROG) begin
      if (timer_reg != 32'h0) begin
        timer_reg <= timer_reg - 32'h1; // [R9]
      end else if (fill_reg) begin
        mem[fill_idx_reg] <= wdata_reg; // [R8]
        fill_idx_reg <= fill_idx_reg + 1'b1;
        if (fill_idx_reg == `SEE_WORDS - 1)
          phase_reg <= PH_IDLE;
      end else begin
        mem[waddr_reg] <= wdata_reg; // [R5]
        phase_reg <= PH_IDLE;
      end
    end else if (state_reg == ST_DATA && clk_rise && sel_s && cnt_reg == 5'h0
                 && enable_reg) begin // [R11] [R14]
      if (fill_reg) begin
        phase_reg <= PH_ERASE; // [R8]
        timer_reg <= FILL_CYC - 1;
      end else begin
        phase_reg <= PH_ERASE; // [R5]
        timer_reg <= PROG_CYC - 1;
      end
      fill_idx_reg <= {`SEE_ADDR_W{1'b0}};
    end
  end

  // command shifter
  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 5'h0;
      head_reg   <= 10'h0;
      shift_reg  <= {`SEE_DATA_W{1'b0}};
      addr_reg   <= {`SEE_ADDR_W{1'b0}};
      enable_reg <= 1'b0; // [R14]
      fill_reg   <= 1'b0;
      wdata_reg  <= {`SEE_DATA_W{1'b0}};
      waddr_reg  <= {`SEE_ADDR_W{1'b0}};
    end else if (!sel_s) begin
      state_reg <= ST_IDLE;
    end else if (clk_rise) begin
      case (state_reg)
        ST_IDLE: begin
          if (din_s && !prog_busy) begin // [R13]
            state_reg <= ST_HEAD;
            cnt_reg   <= 5'd9;
            head_reg  <= 10'h0;
          end
        end
        ST_HEAD: begin
          head_reg <= head_next;
          if (cnt_reg != 5'h0) begin
            cnt_reg <= cnt_reg - 5'h1;
          end else begin
            addr_reg <= head_next[`SEE_ADDR_W-1:0];
            cnt_reg  <= 5'd16;
            state_reg <= ST_DONE;
            if (op_code == `SEE_OP_READ) begin
              state_reg <= ST_READ; // [R16]
              shift_reg <= mem[head_next[`SEE_ADDR_W-1:0]];
            end else if (op_code == `SEE_OP_WRITE) begin
              state_reg <= ST_DATA; // [R4]
              fill_reg  <= 1'b0;
              cnt_reg   <= 5'd15;
            end else if (op_code == `SEE_OP_SPECIAL) begin
              if (sub_code == `SEE_SUB_FILL) begin
                state_reg <= ST_DATA;
                fill_reg  <= 1'b1;
                cnt_reg   <= 5'd15;
              end else if (sub_code == `SEE_SUB_ENABLE)
                enable_reg <= 1'b1;
              else if (sub_code == `SEE_SUB_DISABLE)
                enable_reg <= 1'b0;
            end
          end
        end
        ST_DATA: begin
          wdata_reg <= {wdata_reg[`SEE_DATA_W-2:0], din_s};
          waddr_reg <= addr_reg;
          if (cnt_reg != 5'h0)
            cnt_reg <= cnt_reg - 5'h1;
          else
            state_reg <= ST_DONE;
        end
        ST_READ: begin
          if (cnt_reg != 5'h0) begin
            cnt_reg <= cnt_reg - 5'h1;
            if (cnt_reg != 5'd16)
              shift_reg <= {shift_reg[`SEE_DATA_W-2:0], 1'b0};
          end else begin
            addr_reg  <= addr_reg + 1'b1; // [R3] [R17]
            shift_reg <= mem[addr_reg + 1'b1];
            cnt_reg   <= 5'd15;
          end
        end
        ST_DONE: state_reg <= ST_DONE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // select low timer for status polling
  always @(posedge core_clk) begin
    if (!reset_n) begin
      low_cnt_reg <= 16'h0;
      poll_reg    <= 1'b0;
    end else if (!sel_s) begin
      poll_reg <= 1'b0;
      if (low_cnt_reg != 16'hFFFF)
        low_cnt_reg <= low_cnt_reg + 16'h1;
    end else begin
      if (sel_rise && low_cnt_reg >= `SEE_CSL_CYC && prog_busy)
        poll_reg <= 1'b1; // [R6] [R12]
      low_cnt_reg <= 16'h0;
    end
  end

  // output pin
  always @(posedge core_clk) begin
    if (!reset_n) begin
      serial_out      <= 1'b0;
      serial_out_en_n <= 1'b1;
      busy            <= 1'b0;
    end else begin
      busy <= prog_busy;
      if (!sel_s || sel_fall) begin
        serial_out_en_n <= 1'b1; // [R15]
      end else if (poll_reg) begin
        serial_out_en_n <= 1'b0;
        serial_out      <= ~prog_busy; // [R7]
      end else if (state_reg == ST_READ) begin
        serial_out_en_n <= 1'b0;
        if (clk_rise) begin // [R2]
          if (cnt_reg == 5'd16)
            serial_out <= shift_reg[`SEE_DATA_W-1]; // [R1]
          else if (cnt_reg == 5'h0)
            serial_out <= mem[addr_reg + 1'b1][`SEE_DATA_W-1];
          else
            serial_out <= shift_reg[`SEE_DATA_W-2]; // [R1]
        end
      end else if (state_reg == ST_HEAD && clk_rise && cnt_reg == 5'h0
                   && op_code == `SEE_OP_READ) begin
        // dummy zero on the edge taking the last address bit
        serial_out_en_n <= 1'b0;
        serial_out      <= 1'b0; // [R1]
      end else begin
        serial_out_en_n <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- src/see_regs.vh
// constants for the serial eeprom command engine
`ifndef SEE_REGS_VH
`define SEE_REGS_VH
`define SEE_DATA_W       16
`define SEE_ADDR_W       7
`define SEE_WORDS        128
`define SEE_OP_W         2
`define SEE_OP_SPECIAL   2'h0
`define SEE_OP_WRITE     2'h1
`define SEE_OP_READ      2'h2
`define SEE_OP_ERASE     2'h3
`define SEE_SUB_DISABLE  2'h0
`define SEE_SUB_FILL     2'h1
`define SEE_SUB_ERALL    2'h2
`define SEE_SUB_ENABLE   2'h3
`define SEE_CLK_NS       25
`define SEE_PROG_NS      2000000
`define SEE_PROG_CYC     ((`SEE_PROG_NS + `SEE_CLK_NS - 1) / `SEE_CLK_NS)
`define SEE_FILL_NS      8000000
`define SEE_FILL_CYC     ((`SEE_FILL_NS + `SEE_CLK_NS - 1) / `SEE_CLK_NS)
`define SEE_CSL_NS       250
`define SEE_CSL_CYC      ((`SEE_CSL_NS + `SEE_CLK_NS - 1) / `SEE_CLK_NS)
`define SEE_ERASED       16'hFFFF
`endif
